// ===== src/dcd_defs.svh
/*
 Constants for the display configuration command decoder: opcodes, field
 positions, reset values and the register bus map.
 Assumes it is included by bare name from dcd_core, dcd_top and dcd_tb.
*/
// Functional notes
// - A byte with the command/data line low is a command, high is display data.
// - Opcodes D0, D1, E2 and F0 to FF are reserved and have no effect.
// - Opcode D3 takes one parameter whose low six bits set the row shift 0 to 63.
// - The row shift returns to zero at reset.
// - Opcode D5 takes one parameter whose low nibble selects the clock divider.
// - The divide ratio is the low nibble plus one, and the field resets to zero.
// - The high nibble of the D5 parameter sets the oscillator frequency, reset 0111.
// - In the D8 parameter bits 5:4 select colour mode, 00 mono (reset), 11 area colour.
// - In the D8 parameter bits 2 and 0 both set select low power, both clear normal.
// - The low nibble of the D9 parameter sets pre-charge phase 1 length, reset 2.
// - The high nibble of the D9 parameter sets pre-charge phase 2 length, reset 2.
// - Bit 4 of the DA parameter clear selects sequential row-to-pin ordering.
// - Bit 4 of the DA parameter set selects alternating ordering, the reset default.
// - Opcode DB takes a 7-bit row deselect voltage level, reset 0110101.
// - Opcode E3 is a no-operation that changes no state.
// - Don't-care bits in opcodes and parameters are ignored.
`ifndef DCD_DEFS_SVH
`define DCD_DEFS_SVH

`define DCD_OP_OFFSET 8'hD3
`define DCD_OP_CLKDIV 8'hD5
`define DCD_OP_AREA 8'hD8
`define DCD_OP_PRECHG 8'hD9
`define DCD_OP_COMPIN 8'hDA
`define DCD_OP_DESEL 8'hDB
`define DCD_OP_NOP 8'hE3

`define DCD_RST_OFFSET 6'h00
`define DCD_RST_DIV 4'h0
`define DCD_RST_OSC 4'h7
`define DCD_RST_COLOUR 2'h0
`define DCD_RST_LOWPWR 1'b0
`define DCD_RST_PH1 4'h2
`define DCD_RST_PH2 4'h2
`define DCD_RST_ALTCOM 1'b1
`define DCD_RST_DESEL 7'h35

`define DCD_ADDR_BYTE 4'h0
`define DCD_ADDR_STAT 4'h4
`define DCD_ADDR_CFG0 4'h8
`define DCD_ADDR_CFG1 4'hC
`define DCD_BYTE_DC_BIT 8
`define DCD_OKAY 2'h0
`define DCD_SLVERR 2'h2

`endif

// ===== src/dcd_pkg.sv
/*
 Types for the display configuration command decoder.
 Assumes dcd_defs.svh is on the include path.
*/
package dcd_pkg;
   typedef enum logic [2:0] {
      DCD_ST_OPCODE,
      DCD_ST_PAR_OFFSET,
      DCD_ST_PAR_CLKDIV,
      DCD_ST_PAR_AREA,
      DCD_ST_PAR_PRECHG,
      DCD_ST_PAR_COMPIN,
      DCD_ST_PAR_DESEL
   } dcd_state_t;

   // one received bus byte with its command/data flag
   typedef struct packed {
      logic valid;
      logic is_data;
      logic [7:0] value;
   } dcd_byte_t;

   // decoded display settings
   typedef struct packed {
      logic [5:0] row_offset;
      logic [3:0] clk_div_sel;
      logic [3:0] osc_freq;
      logic [1:0] colour_mode;
      logic low_power;
      logic [3:0] precharge_ph1;
      logic [3:0] precharge_ph2;
      logic alt_com_pins;
      logic [6:0] row_deselect_voltage;
   } dcd_cfg_t;
endpackage

// ===== src/dcd_core.sv
/*
 Command decoder core: takes bytes one at a time and updates settings.
 Assumes bytes arrive as single-cycle valid strokes on the aclk domain.
*/
`timescale 1ns/1ps
`include "dcd_defs.svh"
module dcd_core (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // byte stream
   input dcd_pkg::dcd_byte_t in_byte,
   // decoded settings and status
   output dcd_pkg::dcd_cfg_t cfg,
   output logic param_pending,
   output logic [7:0] data_count
);
   import dcd_pkg::*;

   typedef struct packed {
      dcd_state_t state;
      dcd_cfg_t cfg;
      logic [7:0] data_count;
   } dcd_core_st_t;

   dcd_core_st_t st_ff;
   dcd_core_st_t nxt_st;

   // one byte per valid stroke; data bytes never reach the opcode decoder
   always_comb
   begin
      nxt_st = st_ff;
      if (in_byte.valid)
      begin
         if (in_byte.is_data)
         begin
            nxt_st.data_count = st_ff.data_count + 8'h01;
         end
         else
         begin
            nxt_st.state = DCD_ST_OPCODE;
            case (st_ff.state)
               DCD_ST_OPCODE:
               begin
                  // reserved and nop opcodes fall through with no effect
                  case (in_byte.value)
                     `DCD_OP_OFFSET: nxt_st.state = DCD_ST_PAR_OFFSET;
                     `DCD_OP_CLKDIV: nxt_st.state = DCD_ST_PAR_CLKDIV;
                     `DCD_OP_AREA: nxt_st.state = DCD_ST_PAR_AREA;
                     `DCD_OP_PRECHG: nxt_st.state = DCD_ST_PAR_PRECHG;
                     `DCD_OP_COMPIN: nxt_st.state = DCD_ST_PAR_COMPIN;
                     `DCD_OP_DESEL: nxt_st.state = DCD_ST_PAR_DESEL;
                     `DCD_OP_NOP: nxt_st.state = DCD_ST_OPCODE;
                     default: nxt_st.state = DCD_ST_OPCODE;
                  endcase
               end
               DCD_ST_PAR_OFFSET: nxt_st.cfg.row_offset = in_byte.value[5:0];
               DCD_ST_PAR_CLKDIV:
               begin
                  nxt_st.cfg.clk_div_sel = in_byte.value[3:0];
                  nxt_st.cfg.osc_freq = in_byte.value[7:4];
               end
               DCD_ST_PAR_AREA:
               begin
                  nxt_st.cfg.colour_mode = in_byte.value[5:4];
                  // mixed 10 or 01 patterns keep normal power
                  nxt_st.cfg.low_power = in_byte.value[2] & in_byte.value[0];
               end
               DCD_ST_PAR_PRECHG:
               begin
                  nxt_st.cfg.precharge_ph1 = in_byte.value[3:0];
                  nxt_st.cfg.precharge_ph2 = in_byte.value[7:4];
               end
               DCD_ST_PAR_COMPIN: nxt_st.cfg.alt_com_pins = in_byte.value[4];
               DCD_ST_PAR_DESEL: nxt_st.cfg.row_deselect_voltage = in_byte.value[6:0];
               default: nxt_st.state = DCD_ST_OPCODE;
            endcase
         end
      end
   end

   // power-on defaults
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_ff.state <= DCD_ST_OPCODE;
         st_ff.cfg.row_offset <= `DCD_RST_OFFSET;
         st_ff.cfg.clk_div_sel <= `DCD_RST_DIV;
         st_ff.cfg.osc_freq <= `DCD_RST_OSC;
         st_ff.cfg.colour_mode <= `DCD_RST_COLOUR;
         st_ff.cfg.low_power <= `DCD_RST_LOWPWR;
         st_ff.cfg.precharge_ph1 <= `DCD_RST_PH1;
         st_ff.cfg.precharge_ph2 <= `DCD_RST_PH2;
         st_ff.cfg.alt_com_pins <= `DCD_RST_ALTCOM;
         st_ff.cfg.row_deselect_voltage <= `DCD_RST_DESEL;
         st_ff.data_count <= 8'h00;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign cfg = st_ff.cfg;
   assign param_pending = (st_ff.state != DCD_ST_OPCODE);
   assign data_count = st_ff.data_count;
endmodule

// ===== src/dcd_top.sv
/*
 AXI4-Lite front end of the display configuration command decoder, with
 the divided display clock enable derived from the decoded divider.
 Assumes a single-outstanding master on aclk; writes need the strobes of both
 low lanes, 0 and 1, to push a byte.
*/
`timescale 1ns/1ps
`include "dcd_defs.svh"
module dcd_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address channel
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address channel
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // decoded settings
   output dcd_pkg::dcd_cfg_t cfg,
   output logic dclk_en
);
   import dcd_pkg::*;

   typedef struct packed {
      logic aw_held;
      logic [3:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [3:0] div_cnt;
      logic dclk_en;
   } dcd_top_st_t;

   dcd_top_st_t st_ff;
   dcd_top_st_t nxt_st;
   dcd_byte_t push;
   logic param_pending;
   logic [7:0] data_count;

   dcd_core u_core (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_byte(push),
      .cfg(cfg),
      .param_pending(param_pending),
      .data_count(data_count)
   );

   // channels are accepted only while their holding slot is free
   assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
   assign s_axi_wready = !st_ff.w_held && !st_ff.bvalid;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rresp = st_ff.rresp;
   assign s_axi_rdata = st_ff.rdata;
   assign dclk_en = st_ff.dclk_en;

   // a byte is pushed in the cycle a write with strobe lanes 0 and 1 both set completes to the byte port
   always_comb
   begin
      push.valid = 1'b0;
      push.is_data = st_ff.w_data[`DCD_BYTE_DC_BIT];
      push.value = st_ff.w_data[7:0];
      if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid)
      begin
         if (st_ff.aw_addr == `DCD_ADDR_BYTE)
         begin
            push.valid = st_ff.w_strb[0] & st_ff.w_strb[1];
         end
      end
   end

   always_comb
   begin
      nxt_st = st_ff;
      // write channel capture, either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         nxt_st.aw_held = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         nxt_st.w_held = 1'b1;
         nxt_st.w_data = s_axi_wdata;
         nxt_st.w_strb = s_axi_wstrb;
      end
      if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid)
      begin
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held = 1'b0;
         nxt_st.bvalid = 1'b1;
         // only the byte port is writable; settings change through commands
         if (st_ff.aw_addr == `DCD_ADDR_BYTE)
         begin
            nxt_st.bresp = `DCD_OKAY;
         end
         else
         begin
            nxt_st.bresp = `DCD_SLVERR;
         end
      end
      if (st_ff.bvalid && s_axi_bready)
      begin
         nxt_st.bvalid = 1'b0;
      end
      // read decode
      if (s_axi_arvalid && s_axi_arready)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = `DCD_OKAY;
         if (s_axi_araddr == `DCD_ADDR_BYTE)
         begin
            nxt_st.rdata = 32'h00000000;
         end
         else if (s_axi_araddr == `DCD_ADDR_STAT)
         begin
            nxt_st.rdata = {23'h000000, param_pending, data_count};
         end
         else if (s_axi_araddr == `DCD_ADDR_CFG0)
         begin
            nxt_st.rdata = {8'h00, cfg.osc_freq, cfg.clk_div_sel, 5'h00, cfg.low_power,
               cfg.colour_mode, 2'h0, cfg.row_offset};
         end
         else if (s_axi_araddr == `DCD_ADDR_CFG1)
         begin
            nxt_st.rdata = {8'h00, 1'b0, cfg.row_deselect_voltage, 7'h00, cfg.alt_com_pins,
               cfg.precharge_ph2, cfg.precharge_ph1};
         end
         else
         begin
            nxt_st.rdata = 32'h00000000;
            nxt_st.rresp = `DCD_SLVERR;
         end
      end
      if (st_ff.rvalid && s_axi_rready)
      begin
         nxt_st.rvalid = 1'b0;
      end
      // divided display clock: one pulse every field+1 cycles
      nxt_st.dclk_en = 1'b0;
      if (st_ff.div_cnt >= cfg.clk_div_sel)
      begin
         nxt_st.div_cnt = 4'h0;
         nxt_st.dclk_en = 1'b1;
      end
      else
      begin
         nxt_st.div_cnt = st_ff.div_cnt + 4'h1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end
endmodule

// ===== verification/dcd_chk.sv
/*
 Checker for dcd_top: bus answers, reset settings, quiet settings, enable spacing.
 Assumes it is bound into dcd_top; reset is synchronous and active low.
*/
`timescale 1ns/1ps
module dcd_chk (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // settings
   input wire dcd_pkg::dcd_cfg_t cfg,
   input wire logic dclk_en
);
   import dcd_pkg::*;
   logic [4:0] gap_ff;
   // idle cycles since the last enable; wraps harmlessly if enables stop
   always_ff @(posedge aclk)
      gap_ff <= (!aresetn || dclk_en) ? 5'h00 : gap_ff + 5'h01;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_reset_cfg:
   assert property ($rose(aresetn) |->
      cfg == {6'h00, 4'h0, 4'h7, 2'h0, 1'b0, 4'h2, 4'h2, 1'b1, 7'h35}) else $error("bad reset cfg");
   a_dclk_gap:
   // a divider lowered mid-count may stretch one gap, so the ratio must be settled
   assert property (!dclk_en && $past(aresetn) && $stable(cfg.clk_div_sel)
      |-> gap_ff < {1'b0, cfg.clk_div_sel})
      else $error("enable gap too long");
   a_cfg_quiet:
   assert property ($changed(cfg) |-> $rose(s_axi_bvalid)) else $error("cfg moved alone");
   a_write_answer:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
   a_write_hold:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_write_once:
   assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("double answer");
   a_write_refuse:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("took early");
   a_read_answer:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
   a_read_once:
   assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read not closed");
   c_slow: cover property (dclk_en && cfg.clk_div_sel == 4'h4);
   c_error: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_lowpwr: cover property (cfg.low_power && cfg.colour_mode == 2'h3);
endmodule
bind dcd_top dcd_chk u_chk (.*);

// ===== verification/dcd_host.sv
/*
 Host model: a single-outstanding AXI4-Lite master with write and read tasks.
 Assumes one caller at a time; lag delays taking a write answer.
*/
`timescale 1ns/1ps
module dcd_host (
   // clock
   input wire logic aclk,
   // write side
   output logic [3:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // read side
   output logic [3:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   int lag = 0;
   logic ta;
   logic tw;
   // idle bus from time zero
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // readies are sampled mid-cycle, where they are settled, and acted on at the next edge
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
      @(posedge aclk);
      {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, s, 2'b11};
      do
      begin
         @(negedge aclk);
         {ta, tw} = {awready, wready};
         @(posedge aclk);
         {awvalid, wvalid} <= {awvalid & ~ta, wvalid & ~tw};
      end while (awvalid & ~ta | wvalid & ~tw);
      repeat (lag) @(posedge aclk);
      bready <= 1'b1;
      do
      begin
         @(negedge aclk);
         {ta, r} = {bvalid, bresp};
         @(posedge aclk);
      end while (!ta);
      bready <= 1'b0;
   endtask
   // read: rready stays high from the request until the data is taken
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do
      begin
         @(negedge aclk);
         ta = arready;
         @(posedge aclk);
      end while (!ta);
      arvalid <= 1'b0;
      do
      begin
         @(negedge aclk);
         {ta, d, r} = {rvalid, rdata, rresp};
         @(posedge aclk);
      end while (!ta);
      rready <= 1'b0;
   endtask
endmodule

// ===== verification/dcd_tb.sv
/*
 Testbench for dcd_top: pushes command and data bytes and reads settings back.
 Assumes the host model and the checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "dcd_defs.svh"
module dcd_tb;
   import dcd_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, resp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic dclk_en;
   dcd_cfg_t cfg;
   dcd_cfg_t exp;
   int err_count = 0;
   int tests_run = 0;
   int n;
   logic [7:0] ops [6] = '{8'hD3, 8'hD5, 8'hD8, 8'hD9, 8'hDA, 8'hDB};
   logic [7:0] pars [6] = '{8'hFF, 8'hA4, 8'h35, 8'hF1, 8'h02, 8'hFF};
   logic [7:0] rsv [5] = '{8'hD0, 8'hD1, 8'hE2, 8'hE3, 8'hF7};
   localparam dcd_cfg_t rst_cfg = {6'h00, 4'h0, 4'h7, 2'h0, 1'b0, 4'h2, 4'h2, 1'b1, 7'h35};
   // 100 ns clock
   always #50 aclk = ~aclk;
   dcd_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   dcd_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cfg(cfg), .dclk_en(dclk_en));
   // case equality, so an unknown never matches
   task automatic check(input logic [39:0] g, input logic [39:0] w);
      tests_run++;
      if (g !== w)
      begin
         err_count++;
         $display("ERROR %0t got %h want %h", $time, g, w);
      end
   endtask
   // one bus byte; a high flag marks display data
   task automatic push(input logic flag, input logic [7:0] b);
      host.wr(`DCD_ADDR_BYTE, {23'h0, flag, b}, 4'hF, resp);
      check(resp, `DCD_OKAY);
   endtask
   // settings port and both read-back words against exp
   task automatic check_cfg();
      host.rd(`DCD_ADDR_CFG0, rd, resp);
      check(rd, {8'h00, exp.osc_freq, exp.clk_div_sel, 5'h00, exp.low_power,
         exp.colour_mode, 2'h0, exp.row_offset});
      host.rd(`DCD_ADDR_CFG1, rd, resp);
      check(rd, {9'h0, exp.row_deselect_voltage, 7'h00, exp.alt_com_pins,
         exp.precharge_ph2, exp.precharge_ph1});
      check(cfg, exp);
   endtask
   task automatic finish_test();
      $display("errors %0d of %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // test sequence
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      exp = rst_cfg;
      check_cfg();
      foreach (ops[i])
      begin
         push(1'b0, ops[i]);
         if (i == 0)
            push(1'b1, 8'h5A);
         push(1'b0, pars[i]);
      end
      exp = {6'h3F, 4'h4, 4'hA, 2'h3, 1'b1, 4'h1, 4'hF, 1'b0, 7'h7F};
      check_cfg();
      n = 0;
      repeat (50)
      begin
         @(negedge aclk);
         n += dclk_en;
      end
      check(n, 10);
      host.lag = 3;
      push(1'b1, 8'h66);
      host.lag = 0;
      push(1'b0, 8'hD9);
      host.rd(`DCD_ADDR_STAT, rd, resp);
      check(rd, 32'h102);
      push(1'b0, 8'h22);
      {exp.precharge_ph1, exp.precharge_ph2} = 8'h22;
      // reserved codes and the no-op must leave the next byte as an opcode
      foreach (rsv[i])
      begin
         push(1'b0, rsv[i]);
         push(1'b0, 8'hDA);
         push(1'b0, {3'h0, ~i[0], 4'h2});
         exp.alt_com_pins = ~i[0];
         check_cfg();
      end
      // only one of the two power bits set keeps normal power
      push(1'b0, 8'hD8);
      push(1'b0, 8'h34);
      exp.low_power = 1'b0;
      // a partly strobed byte is dropped, so 07 stays an opcode
      host.wr(`DCD_ADDR_BYTE, 32'h0D3, 4'h1, resp);
      check(resp, `DCD_OKAY);
      host.rd(`DCD_ADDR_STAT, rd, resp);
      check(rd, 32'h002);
      push(1'b0, 8'h07);
      push(1'b0, 8'hD3);
      push(1'b0, 8'hD5);
      push(1'b0, 8'hE3);
      exp.row_offset = 6'h15;
      check_cfg();
      host.wr(`DCD_ADDR_CFG0, 32'h0, 4'hF, resp);
      check(resp, `DCD_SLVERR);
      host.rd(4'h2, rd, resp);
      check({resp, rd}, {`DCD_SLVERR, 32'h0});
      host.rd(`DCD_ADDR_BYTE, rd, resp);
      check({resp, rd}, {`DCD_OKAY, 32'h0});
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      exp = rst_cfg;
      check_cfg();
      host.rd(`DCD_ADDR_STAT, rd, resp);
      check(rd, 32'h0);
      finish_test();
   end
   // watchdog: the run needs well under a millisecond
   initial
   begin
      #1ms;
      err_count++;
      $display("ERROR %0t timeout", $time);
      finish_test();
   end
endmodule
